// ===== rtl/psdl_pkg.sv
// Package for the port strap default loader: register map, field layout, strap defaults.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock.
package psdl_pkg;

  // Register byte addresses.
  localparam logic [7:0] PSDL_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PSDL_ADDR_STRAP_OVR = 8'h04;
  localparam logic [7:0] PSDL_ADDR_STATUS = 8'h08;
  localparam logic [7:0] PSDL_ADDR_P1_FLOWCTL = 8'h0C;
  localparam logic [7:0] PSDL_ADDR_P2_FLOWCTL = 8'h10;
  localparam logic [7:0] PSDL_ADDR_P2_BASIC = 8'h14;
  localparam logic [7:0] PSDL_ADDR_P2_ADVERT = 8'h18;
  localparam logic [7:0] PSDL_ADDR_P2_SPECIAL = 8'h1C;
  localparam logic [7:0] PSDL_ADDR_P1_ADVERT = 8'h20;

  // Control register fields.
  localparam int PSDL_CTRL_RELOAD_BIT = 0;
  localparam int PSDL_CTRL_XOVR_OVR_BIT = 1;

  // Manual flow-control register fields.
  localparam int PSDL_FC_BP_BIT = 0;
  localparam int PSDL_FC_RX_BIT = 1;
  localparam int PSDL_FC_TX_BIT = 2;
  localparam int PSDL_FC_MANUAL_BIT = 3;

  // Basic control fields.
  localparam int PSDL_BASIC_DUPLEX_BIT = 8;
  localparam int PSDL_BASIC_AN_BIT = 12;
  localparam int PSDL_BASIC_SPEED_BIT = 13;

  // Advertisement fields.
  localparam int PSDL_ADV_10HD_BIT = 5;
  localparam int PSDL_ADV_10FD_BIT = 6;
  localparam int PSDL_ADV_100HD_BIT = 7;
  localparam int PSDL_ADV_100FD_BIT = 8;
  localparam int PSDL_ADV_PAUSE_BIT = 10;
  localparam logic [4:0] PSDL_ADV_SELECTOR = 5'h01;

  // Special mode / crossover fields.
  localparam int PSDL_SPC_MODE_LSB = 0;
  localparam int PSDL_SPC_XOVR_AUTO_BIT = 4;
  localparam int PSDL_SPC_XOVR_CROSS_BIT = 5;

  // Status fields.
  localparam int PSDL_STAT_LOADED_BIT = 0;
  localparam int PSDL_STAT_EE_BIT = 1;

  // Operating select encodings.
  localparam logic [2:0] PSDL_MODE_10HD = 3'h0;
  localparam logic [2:0] PSDL_MODE_10FD = 3'h1;
  localparam logic [2:0] PSDL_MODE_100HD = 3'h2;
  localparam logic [2:0] PSDL_MODE_100FD = 3'h3;
  localparam logic [2:0] PSDL_MODE_AN_ALL = 3'h7;

  // Strap defaults when no pin or loader supplies a value.
  localparam logic PSDL_DEF_P1_MANUAL = 1'b0;
  localparam logic PSDL_DEF_P2_AUTO_XOVR = 1'b1;
  localparam logic PSDL_DEF_P2_MANUAL_XOVR = 1'b0;
  localparam logic PSDL_DEF_P2_AUTONEG = 1'b1;
  localparam logic PSDL_DEF_P2_SPEED = 1'b1;
  localparam logic PSDL_DEF_P2_DUPLEX = 1'b1;
  localparam logic PSDL_DEF_P2_BP = 1'b1;
  localparam logic PSDL_DEF_P2_FDFC = 1'b1;

  // AXI response codes.
  localparam logic [1:0] PSDL_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSDL_RESP_SLVERR = 2'h2;

  // One set of soft strap values.
  typedef struct packed {
    logic p1_manual_flowctl_strap;
    logic p2_auto_xovr_strap;
    logic p2_manual_xovr_strap;
    logic p2_autoneg_strap;
    logic p2_speed_strap;
    logic p2_duplex_strap;
    logic p2_backpressure_strap;
    logic p2_fullduplex_flowctl_strap;
  } psdl_strap_type;

  localparam psdl_strap_type PSDL_STRAP_DEFAULT = '{
    PSDL_DEF_P1_MANUAL, PSDL_DEF_P2_AUTO_XOVR, PSDL_DEF_P2_MANUAL_XOVR,
    PSDL_DEF_P2_AUTONEG, PSDL_DEF_P2_SPEED, PSDL_DEF_P2_DUPLEX,
    PSDL_DEF_P2_BP, PSDL_DEF_P2_FDFC};

  // Derived register defaults.
  typedef struct packed {
    logic [15:0] p2_basic;
    logic [15:0] p2_advert;
    logic [15:0] p2_special;
    logic [15:0] p1_advert;
    logic [3:0] p1_flowctl;
    logic [3:0] p2_flowctl;
  } psdl_dflt_type;

endpackage

// ===== rtl/psdl_derive.sv
// Combinational mapping from latched strap values to register defaults.
// Assumes the strap set is stable while the caller captures the result.
`timescale 1ns/1ps
module psdl_derive (
  input wire psdl_pkg::psdl_strap_type i_strap,
  output psdl_pkg::psdl_dflt_type o_dflt
);
  import psdl_pkg::*;

  // Builds every default word from the strap set.
  always_comb begin
    o_dflt = '0;
    // Manual select low keeps symmetric pause advertised; high clears it.
    o_dflt.p1_advert[PSDL_ADV_PAUSE_BIT] = ~i_strap.p1_manual_flowctl_strap;
    o_dflt.p1_advert[4:0] = PSDL_ADV_SELECTOR;
    o_dflt.p1_flowctl[PSDL_FC_MANUAL_BIT] = i_strap.p1_manual_flowctl_strap;
    o_dflt.p1_flowctl[PSDL_FC_TX_BIT] = 1'b1;
    o_dflt.p1_flowctl[PSDL_FC_RX_BIT] = 1'b1;
    o_dflt.p1_flowctl[PSDL_FC_BP_BIT] = 1'b1;
    // Port 2 basic control: negotiation, speed and duplex.
    o_dflt.p2_basic[PSDL_BASIC_AN_BIT] = i_strap.p2_autoneg_strap;
    o_dflt.p2_basic[PSDL_BASIC_SPEED_BIT] = i_strap.p2_speed_strap;
    o_dflt.p2_basic[PSDL_BASIC_DUPLEX_BIT] = i_strap.p2_duplex_strap;
    // Port 2 advertisement: 100 Mb abilities follow speed and duplex straps; 10 Mb ones are also set when negotiating.
    o_dflt.p2_advert[4:0] = PSDL_ADV_SELECTOR;
    o_dflt.p2_advert[PSDL_ADV_PAUSE_BIT] = 1'b1;
    o_dflt.p2_advert[PSDL_ADV_100FD_BIT] = i_strap.p2_speed_strap & i_strap.p2_duplex_strap;
    o_dflt.p2_advert[PSDL_ADV_100HD_BIT] = i_strap.p2_speed_strap;
    o_dflt.p2_advert[PSDL_ADV_10FD_BIT] = i_strap.p2_autoneg_strap
        | (~i_strap.p2_speed_strap & i_strap.p2_duplex_strap);
    o_dflt.p2_advert[PSDL_ADV_10HD_BIT] = i_strap.p2_autoneg_strap
        | ~i_strap.p2_speed_strap;
    // Operating select: all-capable when negotiating, else the forced mode.
    if (i_strap.p2_autoneg_strap) begin
      o_dflt.p2_special[PSDL_SPC_MODE_LSB +: 3] = PSDL_MODE_AN_ALL;
    end else begin
      case ({i_strap.p2_speed_strap, i_strap.p2_duplex_strap})
        2'h0: o_dflt.p2_special[PSDL_SPC_MODE_LSB +: 3] = PSDL_MODE_10HD;
        2'h1: o_dflt.p2_special[PSDL_SPC_MODE_LSB +: 3] = PSDL_MODE_10FD;
        2'h2: o_dflt.p2_special[PSDL_SPC_MODE_LSB +: 3] = PSDL_MODE_100HD;
        default: o_dflt.p2_special[PSDL_SPC_MODE_LSB +: 3] = PSDL_MODE_100FD;
      endcase
    end
    o_dflt.p2_special[PSDL_SPC_XOVR_AUTO_BIT] = i_strap.p2_auto_xovr_strap;
    o_dflt.p2_special[PSDL_SPC_XOVR_CROSS_BIT] = i_strap.p2_manual_xovr_strap;
    // Port 2 manual flow control defaults.
    o_dflt.p2_flowctl[PSDL_FC_BP_BIT] = i_strap.p2_backpressure_strap;
    o_dflt.p2_flowctl[PSDL_FC_TX_BIT] = i_strap.p2_fullduplex_flowctl_strap;
    o_dflt.p2_flowctl[PSDL_FC_RX_BIT] = i_strap.p2_fullduplex_flowctl_strap;
    o_dflt.p2_flowctl[PSDL_FC_MANUAL_BIT] = 1'b0;
  end

endmodule

// ===== rtl/psdl_top.sv
// Soft strap default loader: latches straps, derives PHY and flow-control defaults,
// and exposes them through AXI4-Lite registers and decoded outputs.
// Assumes strap pins settle during reset
// and a one-cycle loader valid pulse.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module psdl_top (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire psdl_pkg::psdl_strap_type I_STRAP_PINS,
  input wire psdl_pkg::psdl_strap_type I_EE_STRAP,
  input wire logic I_EE_STRAP_VALID,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_DEFAULTS_LOADED,
  output logic O_P2_AUTO_XOVR_EN,
  output logic O_P2_XOVR_CROSSED,
  output logic O_P1_PAUSE_BY_AN,
  output logic O_P1_TX_PAUSE_EN,
  output logic O_P1_RX_PAUSE_EN
);
  import psdl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser.

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  // Two flops release the asynchronous reset cleanly.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture and load sequencing.

  typedef enum logic [1:0] {PSDL_ST_SAMPLE, PSDL_ST_LOAD, PSDL_ST_RUN} psdl_state_type;

  psdl_state_type state_ff;
  psdl_strap_type strap_ff;
  logic ee_used_ff;
  logic load_pulse;
  logic reload_req;
  psdl_dflt_type dflt;

  // Loads happen in the cycle after a strap set is captured.
  assign load_pulse = (state_ff == PSDL_ST_LOAD);

  // Pins sampled after reset; loader sets replace them.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= PSDL_ST_SAMPLE;
      strap_ff <= PSDL_STRAP_DEFAULT;
      ee_used_ff <= 1'b0;
    end else begin
      case (state_ff)
        PSDL_ST_SAMPLE: begin
          strap_ff <= I_STRAP_PINS;
          state_ff <= PSDL_ST_LOAD;
        end
        PSDL_ST_LOAD: begin
          state_ff <= PSDL_ST_RUN;
        end
        default: begin
          if (I_EE_STRAP_VALID) begin
            strap_ff <= I_EE_STRAP;
            ee_used_ff <= 1'b1;
            state_ff <= PSDL_ST_LOAD;
          end else if (reload_req) begin
            strap_ff <= I_STRAP_PINS;
            ee_used_ff <= 1'b0;
            state_ff <= PSDL_ST_LOAD;
          end
        end
      endcase
    end
  end

  // Strap to default mapping.
  psdl_derive u_derive (
    .i_strap(strap_ff),
    .o_dflt(dflt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  logic aw_held_ff;
  logic [7:0] aw_addr_ff;
  logic w_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] wmask;

  assign O_AWREADY = ~aw_held_ff & ~bvalid_ff;
  assign O_WREADY = ~w_held_ff & ~bvalid_ff;
  assign wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  // Address and data taken in either order.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= I_AWADDR;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_held_ff <= 1'b1;
        w_data_ff <= I_WDATA;
        w_strb_ff <= I_WSTRB;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped or read-only addresses.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= PSDL_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? PSDL_RESP_OKAY : PSDL_RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [31:0] ctrl_ff;
  logic [31:0] strap_ovr_ff;
  logic [3:0] p1_fc_ff;
  logic [3:0] p2_fc_ff;
  logic [15:0] p2_basic_ff;
  logic [15:0] p2_adv_ff;
  logic [15:0] p2_spc_ff;
  logic [15:0] p1_adv_ff;
  logic [31:0] nxt_wr;

  // Address decode for writable registers.
  always_comb begin
    wr_hit = 1'b1;
    if (aw_addr_ff == PSDL_ADDR_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_STRAP_OVR) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P1_FLOWCTL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P2_FLOWCTL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P2_BASIC) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P2_ADVERT) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P2_SPECIAL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_ff == PSDL_ADDR_P1_ADVERT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Merged write value, shared by all registers through the byte strobes.
  function automatic logic [31:0] psdl_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [31:0] mask);
    psdl_merge = (old_val & ~mask) | (new_val & mask);
  endfunction
  assign nxt_wr = w_data_ff;

  // Control register; the reload bit self-clears.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 32'h0000_0000;
      strap_ovr_ff <= 32'h0000_0000;
    end else if (wr_fire && aw_addr_ff == PSDL_ADDR_CTRL) begin
      ctrl_ff <= psdl_merge(ctrl_ff, nxt_wr, wmask);
    end else begin
      ctrl_ff[PSDL_CTRL_RELOAD_BIT] <= 1'b0;
      if (wr_fire && aw_addr_ff == PSDL_ADDR_STRAP_OVR) begin
        strap_ovr_ff <= psdl_merge(strap_ovr_ff, nxt_wr, wmask);
      end
    end
  end
  assign reload_req = ctrl_ff[PSDL_CTRL_RELOAD_BIT];

  // Defaults reload on every strap load; software writes follow.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      p1_fc_ff <= 4'h0;
      p2_fc_ff <= 4'h0;
      p2_basic_ff <= 16'h0000;
      p2_adv_ff <= 16'h0000;
      p2_spc_ff <= 16'h0000;
      p1_adv_ff <= 16'h0000;
    end else if (load_pulse) begin
      p1_fc_ff <= dflt.p1_flowctl;
      p2_fc_ff <= dflt.p2_flowctl;
      p2_basic_ff <= dflt.p2_basic;
      p2_adv_ff <= dflt.p2_advert;
      p2_spc_ff <= dflt.p2_special;
      p1_adv_ff <= dflt.p1_advert;
    end else if (wr_fire) begin
      if (aw_addr_ff == PSDL_ADDR_P1_FLOWCTL) begin
        p1_fc_ff <= 4'(psdl_merge({28'h0, p1_fc_ff}, nxt_wr, wmask));
      end else if (aw_addr_ff == PSDL_ADDR_P2_FLOWCTL) begin
        p2_fc_ff <= 4'(psdl_merge({28'h0, p2_fc_ff}, nxt_wr, wmask));
      end else if (aw_addr_ff == PSDL_ADDR_P2_BASIC) begin
        p2_basic_ff <= 16'(psdl_merge({16'h0, p2_basic_ff}, nxt_wr, wmask));
      end else if (aw_addr_ff == PSDL_ADDR_P2_ADVERT) begin
        p2_adv_ff <= 16'(psdl_merge({16'h0, p2_adv_ff}, nxt_wr, wmask));
      end else if (aw_addr_ff == PSDL_ADDR_P2_SPECIAL) begin
        p2_spc_ff <= 16'(psdl_merge({16'h0, p2_spc_ff}, nxt_wr, wmask));
      end else if (aw_addr_ff == PSDL_ADDR_P1_ADVERT) begin
        p1_adv_ff <= 16'(psdl_merge({16'h0, p1_adv_ff}, nxt_wr, wmask));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossover and flow-control decode.

  logic xovr_ovr;
  logic nxt_auto_xovr;
  logic nxt_crossed;
  logic loaded_ff;

  assign xovr_ovr = ctrl_ff[PSDL_CTRL_XOVR_OVR_BIT];

  // Override selects software bits; otherwise the port 2 special register bits decide.
  always_comb begin
    if (xovr_ovr) begin
      nxt_auto_xovr = strap_ovr_ff[PSDL_SPC_XOVR_AUTO_BIT];
      nxt_crossed = strap_ovr_ff[PSDL_SPC_XOVR_CROSS_BIT];
    end else begin
      nxt_auto_xovr = p2_spc_ff[PSDL_SPC_XOVR_AUTO_BIT];
      nxt_crossed = ~p2_spc_ff[PSDL_SPC_XOVR_AUTO_BIT]
          & p2_spc_ff[PSDL_SPC_XOVR_CROSS_BIT];
    end
  end

  // Decoded outputs are registered and valid once the first load completes.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
      O_P2_AUTO_XOVR_EN <= 1'b0;
      O_P2_XOVR_CROSSED <= 1'b0;
      O_P1_PAUSE_BY_AN <= 1'b0;
      O_P1_TX_PAUSE_EN <= 1'b0;
      O_P1_RX_PAUSE_EN <= 1'b0;
    end else begin
      if (state_ff == PSDL_ST_RUN) begin
        loaded_ff <= 1'b1;
      end
      O_P2_AUTO_XOVR_EN <= nxt_auto_xovr;
      O_P2_XOVR_CROSSED <= nxt_crossed;
      O_P1_PAUSE_BY_AN <= ~p1_fc_ff[PSDL_FC_MANUAL_BIT];
      O_P1_TX_PAUSE_EN <= p1_fc_ff[PSDL_FC_MANUAL_BIT] & p1_fc_ff[PSDL_FC_TX_BIT];
      O_P1_RX_PAUSE_EN <= p1_fc_ff[PSDL_FC_MANUAL_BIT] & p1_fc_ff[PSDL_FC_RX_BIT];
    end
  end
  assign O_DEFAULTS_LOADED = loaded_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] nxt_rdata;
  logic rd_hit;

  assign O_ARREADY = ~rvalid_ff;

  // Read multiplexer; unmapped addresses read zero with an error.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    rd_hit = 1'b1;
    if (I_ARADDR == PSDL_ADDR_CTRL) begin
      nxt_rdata = ctrl_ff;
    end else if (I_ARADDR == PSDL_ADDR_STRAP_OVR) begin
      nxt_rdata = strap_ovr_ff;
    end else if (I_ARADDR == PSDL_ADDR_STATUS) begin
      nxt_rdata[PSDL_STAT_LOADED_BIT] = loaded_ff;
      nxt_rdata[PSDL_STAT_EE_BIT] = ee_used_ff;
      nxt_rdata[15:8] = strap_ff;
    end else if (I_ARADDR == PSDL_ADDR_P1_FLOWCTL) begin
      nxt_rdata[3:0] = p1_fc_ff;
    end else if (I_ARADDR == PSDL_ADDR_P2_FLOWCTL) begin
      nxt_rdata[3:0] = p2_fc_ff;
    end else if (I_ARADDR == PSDL_ADDR_P2_BASIC) begin
      nxt_rdata[15:0] = p2_basic_ff;
    end else if (I_ARADDR == PSDL_ADDR_P2_ADVERT) begin
      nxt_rdata[15:0] = p2_adv_ff;
    end else if (I_ARADDR == PSDL_ADDR_P2_SPECIAL) begin
      nxt_rdata[15:0] = p2_spc_ff;
    end else if (I_ARADDR == PSDL_ADDR_P1_ADVERT) begin
      nxt_rdata[15:0] = p1_adv_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read data is registered one cycle after the address is taken.
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= PSDL_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= rd_hit ? PSDL_RESP_OKAY : PSDL_RESP_SLVERR;
    end else if (I_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;

endmodule

// ===== testbench/psdl_sva.sv
// Checker for the strap default loader.
// Assumes it is bound into psdl_top and sees only that module's ports.
`timescale 1ns/1ps
module psdl_sva (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire psdl_pkg::psdl_strap_type I_STRAP_PINS,
  input wire psdl_pkg::psdl_strap_type I_EE_STRAP,
  input wire logic I_EE_STRAP_VALID,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_DEFAULTS_LOADED,
  input wire logic O_P2_AUTO_XOVR_EN,
  input wire logic O_P2_XOVR_CROSSED,
  input wire logic O_P1_PAUSE_BY_AN,
  input wire logic O_P1_TX_PAUSE_EN,
  input wire logic O_P1_RX_PAUSE_EN
);
  import psdl_pkg::*;
  logic [3:0] up_cnt_ff;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since reset release.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      up_cnt_ff <= 4'h0;
    end else if (up_cnt_ff != 4'hF) begin
      up_cnt_ff <= up_cnt_ff + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Strap sampling and decoded outputs.
  chk_load_bound: assert property (up_cnt_ff >= 4'h7 |-> O_DEFAULTS_LOADED)
    else $error("late load");
  chk_loaded_holds: assert property (O_DEFAULTS_LOADED |=> O_DEFAULTS_LOADED)
    else $error("load dropped");
  chk_an_excl: assert property (O_P1_PAUSE_BY_AN |-> !O_P1_TX_PAUSE_EN && !O_P1_RX_PAUSE_EN)
    else $error("pause overlap");
  chk_first_p1: assert property ($rose(O_DEFAULTS_LOADED) |->
    O_P1_PAUSE_BY_AN == !I_STRAP_PINS.p1_manual_flowctl_strap)
    else $error("p1 select");
  chk_first_xovr: assert property ($rose(O_DEFAULTS_LOADED) |->
    O_P2_AUTO_XOVR_EN == I_STRAP_PINS.p2_auto_xovr_strap && O_P2_XOVR_CROSSED ==
    (!I_STRAP_PINS.p2_auto_xovr_strap && I_STRAP_PINS.p2_manual_xovr_strap))
    else $error("p2 xovr");
  chk_ee_xovr: assert property (I_EE_STRAP_VALID && O_DEFAULTS_LOADED |-> ##3
    O_P2_AUTO_XOVR_EN == $past(I_EE_STRAP.p2_auto_xovr_strap, 3))
    else $error("ee xovr");
  chk_ee_p1: assert property (I_EE_STRAP_VALID && O_DEFAULTS_LOADED |-> ##3
    O_P1_PAUSE_BY_AN == !$past(I_EE_STRAP.p1_manual_flowctl_strap, 3))
    else $error("ee select");
  // Bus response timing, holding and read blocking.
  chk_b_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
    |-> ##[1:2] O_BVALID) else $error("no bresp");
  chk_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("bresp held");
  chk_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("rdata held");
  chk_ar_block: assert property (O_RVALID |-> !O_ARREADY)
    else $error("ar busy");
  cover property ($rose(O_DEFAULTS_LOADED));
  cover property (I_EE_STRAP_VALID && O_DEFAULTS_LOADED);
  cover property (O_P2_XOVR_CROSSED);
  cover property (O_BVALID && !I_BREADY);
endmodule
bind psdl_top psdl_sva u_sva (.*);

// ===== testbench/psdl_strap_model.sv
// Model of the strap pins and the serial loader that feed the strap inputs.
// Assumes the bench changes pin levels only while reset is held.
`timescale 1ns/1ps
module psdl_strap_model (
  input wire logic i_clk,
  input wire psdl_pkg::psdl_strap_type i_pins,
  input wire psdl_pkg::psdl_strap_type i_ee,
  input wire logic i_go,
  output psdl_pkg::psdl_strap_type o_pins,
  output psdl_pkg::psdl_strap_type o_ee,
  output logic o_valid
);
  import psdl_pkg::*;
  // Pins hold their board level.
  assign o_pins = i_pins;
  // Loader shows a set for one cycle, then inverted stale data.
  initial o_valid = 1'b0;
  initial o_ee = '0;
  always @(posedge i_clk) begin
    o_valid <= i_go;
    o_ee <= i_go ? i_ee : ~o_ee;
  end
endmodule

// ===== testbench/psdl_top_tb_top.sv
// Bench for the strap default loader.
// Assumes package, design, model and checker compile first.
`timescale 1ns/1ps
module psdl_top_tb_top;
  import psdl_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, seed = 32'h000037B5;
  psdl_strap_type pin_s = PSDL_STRAP_DEFAULT, ee_s = '0, pins, ee;
  logic ee_v, awr, wrd, bv, arr, rv, ld, axe, xc, pan, ptx, prx;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  logic [65:0] re;
  int n_fail = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  psdl_strap_model u_mdl (.i_clk(clk), .i_pins(pin_s), .i_ee(ee_s), .i_go(go),
    .o_pins(pins), .o_ee(ee), .o_valid(ee_v));
  psdl_top dut (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_STRAP_PINS(pins), .I_EE_STRAP(ee),
    .I_EE_STRAP_VALID(ee_v), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(bresp),
    .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rr),
    .O_DEFAULTS_LOADED(ld), .O_P2_AUTO_XOVR_EN(axe), .O_P2_XOVR_CROSSED(xc),
    .O_P1_PAUSE_BY_AN(pan), .O_P1_TX_PAUSE_EN(ptx), .O_P1_RX_PAUSE_EN(prx));
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic miss(input string m);
    n_fail++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic cmp(input logic a, input logic e, input string m);
    n_checks++;
    if (a !== e) miss(m);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (bq.size() + rq.size() != 0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      miss("drain");
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ta, tw;
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrd;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
    end while (((awv && !ta) || (wv && !tw)) && n < 50);
    if (n >= 50) miss("aw w");
    drain();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    logic t;
    rq.push_back({r, m, e});
    ara <= a;
    arv <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      t = arv && arr;
      @(posedge clk);
      if (t) arv <= 1'b0;
      n++;
    end while (!t && n < 50);
    if (n >= 50) miss("ar");
    drain();
  endtask
  // Checks the defaults for one strap set, apart from the masked 100 Mb advert, cross, p1 selector and (when negotiating) basic speed and duplex bits.
  task automatic chk_all(input psdl_strap_type s);
    logic an, sp, dp;
    an = s.p2_autoneg_strap;
    sp = s.p2_speed_strap;
    dp = s.p2_duplex_strap;
    rd(PSDL_ADDR_P2_BASIC, {18'h0, sp, an, 3'h0, dp, 8'h00}, an ? 32'hFFFFDEFF : 32'hFFFFFFFF,
      PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P2_ADVERT, {21'h0, 1'b1, 3'h0, an | (!sp && dp), an | !sp, 5'h01},
      32'hFFFFFE7F, PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P2_SPECIAL, {27'h0, s.p2_auto_xovr_strap, 1'b0, an ? 3'h7 : {1'b0, sp, dp}},
      32'hFFFFFFDF, PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P1_FLOWCTL, {28'h0, s.p1_manual_flowctl_strap, 3'h7}, 32'hFFFFFFFF,
      PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P2_FLOWCTL, {29'h0, s.p2_fullduplex_flowctl_strap,
      s.p2_fullduplex_flowctl_strap, s.p2_backpressure_strap}, 32'hF, PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P1_ADVERT, {21'h0, !s.p1_manual_flowctl_strap, 10'h000}, 32'h400,
      PSDL_RESP_OKAY);
    cmp(pan, !s.p1_manual_flowctl_strap, "p1 an");
    cmp(ptx, s.p1_manual_flowctl_strap, "p1 tx");
    cmp(prx, s.p1_manual_flowctl_strap, "p1 rx");
    cmp(axe, s.p2_auto_xovr_strap, "p2 auto");
    cmp(xc, !s.p2_auto_xovr_strap && s.p2_manual_xovr_strap, "p2 cross");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog, stalls, monitor.
  initial forever #10 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    miss("watchdog");
    stop_test();
  end
  always @(posedge clk) begin
    if (!br || bv) br <= ^xs();
    if (!rr || rv) rr <= ^xs();
  end
  always @(posedge clk) begin
    if (bv && br) begin
      n_checks++;
      if (bq.size() == 0) begin
        miss("extra bresp");
      end else if (bresp !== bq.pop_front()) begin
        miss("bresp");
      end
    end
    if (rv && rr) begin
      n_checks++;
      if (rq.size() == 0) begin
        miss("extra rdata");
      end else begin
        re = rq.pop_front();
        if (((rdata ^ re[31:0]) & re[63:32]) !== 32'h0 || rresp !== re[65:64]) miss("rdata");
      end
    end
  end
  // Pin straps over resets, loader sets, bus cases.
  initial begin
    psdl_strap_type s;
    for (int k = 0; k < 8; k++) begin
      s = k == 0 ? PSDL_STRAP_DEFAULT : psdl_strap_type'(8'(xs()));
      if (k == 1) s[6:5] = 2'h1;
      pin_s <= s;
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
      chk_all(s);
    end
    for (int k = 0; k < 4; k++) begin
      s = psdl_strap_type'(8'(xs()));
      ee_s <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (6) @(posedge clk);
      chk_all(s);
    end
    rd(PSDL_ADDR_STATUS, 32'h3, 32'h3, PSDL_RESP_OKAY);
    wr(PSDL_ADDR_STATUS, 32'h0, PSDL_RESP_SLVERR);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, PSDL_RESP_SLVERR);
    wr(PSDL_ADDR_P2_FLOWCTL, 32'h5, PSDL_RESP_OKAY);
    rd(PSDL_ADDR_P2_FLOWCTL, 32'h5, 32'hFFFFFFFF, PSDL_RESP_OKAY);
    wr(PSDL_ADDR_STRAP_OVR, {26'h0, !s.p2_auto_xovr_strap, s.p2_auto_xovr_strap, 4'h0},
      PSDL_RESP_OKAY);
    wr(PSDL_ADDR_CTRL, 32'h2, PSDL_RESP_OKAY);
    repeat (3) @(posedge clk);
    cmp(axe, s.p2_auto_xovr_strap, "ovr auto");
    cmp(xc, !s.p2_auto_xovr_strap, "ovr cross");
    stop_test();
  end
endmodule
